// file: hw/ensc_pkg.sv
package ensc_pkg;
	// Counter widths and counts
	localparam int OCT_W = 16;
	localparam int FC_W = 32;
	localparam int OC_W = 64;
	localparam int NUM_FC = 13;
	localparam int NUM_OC = 5;
	localparam int NUM_RX_FC = 9;
	localparam int NUM_RX_OC = 3;
	localparam logic [3:0] FC_LAST = 4'hC;
	localparam logic [2:0] OC_LAST = 3'h4;
	// Frame counter slots
	localparam int RX_NORM = 0;
	localparam int RX_URG = 1;
	localparam int RX_NULL = 2;
	localparam int RX_LONG = 3;
	localparam int RX_GOOD = 4;
	localparam int RX_BC = 5;
	localparam int RX_MC = 6;
	localparam int RX_MARK = 7;
	localparam int RX_DMG = 8;
	localparam int TX_URG = 9;
	localparam int TX_TOT = 10;
	localparam int TX_BC = 11;
	localparam int TX_MC = 12;
	// Octet counter slots
	localparam int O_RX_NORM = 0;
	localparam int O_RX_URG = 1;
	localparam int O_RX_GOOD = 2;
	localparam int O_TX_URG = 3;
	localparam int O_TX_TOT = 4;
	// Frame size limits
	localparam logic [15:0] MIN_NULL_OCT = 16'h0006;
	localparam logic [15:0] MAX_SMALL = 16'h05EE;
	localparam logic [15:0] MAX_LARGE = 16'h11A8;
	// Address bits
	localparam int GROUP_BIT = 40;
	localparam logic [47:0] BCAST_ADDR = 48'hFFFFFFFFFFFF;
	// Training configuration field layout
	localparam int CFG_FMT_LSB = 11;
	localparam int CFG_ACC_LSB = 8;
	// Framing format codes
	localparam logic [1:0] FMT_FIRST = 2'h1;
	localparam logic [1:0] FMT_SECOND = 2'h2;
	localparam logic [1:0] FMT_EITHER = 2'h3;
	// Link state code meaning training succeeded
	localparam logic [2:0] LS_OPENED = 3'h1;
	// Register byte offsets
	localparam logic [11:0] FC_BASE = 12'h000;
	localparam logic [11:0] OC_BASE = 12'h040;
	localparam logic [11:0] CTRL_OFF = 12'h080;
	localparam logic [11:0] FMASK_OFF = 12'h084;
	localparam logic [11:0] TCFG_OFF = 12'h088;
	localparam logic [11:0] CAPS_OFF = 12'h08C;
	localparam logic [11:0] STAT_OFF = 12'h090;
	// Control register layout and reset
	localparam int CTRL_ACC_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h3;
	// Received packet status
	typedef enum logic [1:0] {PKT_NULL, PKT_VALID, PKT_MARK, PKT_ERR} ensc_pkt_e;
endpackage : ensc_pkg

// file: hw/ensc_rx_if.sv
interface ensc_rx_if;
	import ensc_pkg::*;
	logic done; // End of received frame
	logic [OCT_W-1:0] octets; // Frame length
	logic [47:0] dest; // Destination address
	logic urgent; // High priority
	logic null_addr; // Null-addressed flag
	logic fcs_bad; // Checksum failed
	logic marker; // Invalid packet marker seen
	logic medium_err; // Other medium symbol errors
	logic undersize; // Too short
	logic bad_start; // Bad start delimiter
	logic bad_end; // Bad end marker
	logic use_small; // Smaller size limit applies
	ensc_pkt_e status; // Derived status
	logic [NUM_RX_FC-1:0] fc_inc; // Frame counter strobes
	logic [NUM_RX_OC-1:0] oc_inc; // Octet counter strobes
	modport cls(input done, octets, dest, urgent, null_addr, fcs_bad, marker, medium_err,
		undersize, bad_start, bad_end, use_small, output status, fc_inc, oc_inc);
	modport top(output done, octets, dest, urgent, null_addr, fcs_bad, marker, medium_err,
		undersize, bad_start, bad_end, use_small, input status, fc_inc, oc_inc);
endinterface : ensc_rx_if

// file: hw/ensc_counter.sv
module ensc_counter
	import ensc_pkg::*;
	#(parameter int W = 32)
	(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Update
	input wire logic en,
	input wire logic [W-1:0] amt,
	// Value
	output logic [W-1:0] cnt
	);
	// Unsigned accumulate, wraps past the top of range
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else if (en) begin
			cnt <= cnt + amt;
		end
	end
endmodule : ensc_counter

// file: hw/ensc_rx_classify.sv
module ensc_rx_classify
	import ensc_pkg::*;
	(
	// Frame facts in, counter strobes out
	ensc_rx_if.cls rx
	);
	logic err_any; // Any data error
	logic null_hit; // Counted as null frame
	logic too_long; // Counted as oversize
	logic grp; // Group address
	logic bcast; // Broadcast address

	// Error status and marker qualification
	assign err_any = (rx.fcs_bad && !rx.marker) || rx.medium_err || rx.undersize ||
		rx.bad_start || rx.bad_end;
	assign null_hit = rx.null_addr && (rx.octets >= MIN_NULL_OCT);
	assign too_long = (rx.octets > MAX_LARGE) || ((rx.octets > MAX_SMALL) && rx.use_small);
	assign grp = rx.dest[GROUP_BIT];
	assign bcast = (rx.dest == BCAST_ADDR);

	// Status: null first, then error, then marker
	always_comb begin
		if (rx.null_addr) begin
			rx.status = PKT_NULL;
		end else if (err_any) begin
			rx.status = PKT_ERR;
		end else if (rx.marker) begin
			rx.status = PKT_MARK;
		end else begin
			rx.status = PKT_VALID;
		end
	end

	// Counter strobes; every frame is counted whatever its address
	always_comb begin
		rx.fc_inc = '0;
		rx.oc_inc = '0;
		if (rx.done) begin
			// Priority split, promoted frames arrive as normal
			rx.fc_inc[rx.urgent ? RX_URG : RX_NORM] = 1'b1;
			rx.oc_inc[rx.urgent ? O_RX_URG : O_RX_NORM] = 1'b1;
			if (null_hit) begin
				rx.fc_inc[RX_NULL] = 1'b1;
			end else if (too_long) begin
				rx.fc_inc[RX_LONG] = 1'b1;
			end else begin
				case (rx.status)
					PKT_VALID: begin
						rx.fc_inc[RX_GOOD] = 1'b1;
						rx.oc_inc[O_RX_GOOD] = 1'b1;
						if (grp) begin
							rx.fc_inc[bcast ? RX_BC : RX_MC] = 1'b1;
						end
					end
					PKT_MARK: rx.fc_inc[RX_MARK] = 1'b1;
					PKT_ERR: rx.fc_inc[RX_DMG] = 1'b1;
					default: ;
				endcase
			end
		end
	end
endmodule : ensc_rx_classify

// file: hw/ensc_top.sv
// The implementer's own choices: the register addresses and the APB interface to the registers.
module ensc_top
	import ensc_pkg::*;
	#(parameter logic [1:0] SUPPORTED = FMT_EITHER) // Capability code
	(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Received frame report
	input wire logic rx_done,
	input wire logic [15:0] rx_octets,
	input wire logic [47:0] rx_dest,
	input wire logic rx_urgent,
	input wire logic rx_null_addr,
	input wire logic rx_fcs_bad,
	input wire logic rx_marker,
	input wire logic rx_medium_err,
	input wire logic rx_undersize,
	input wire logic rx_bad_start,
	input wire logic rx_bad_end,
	// Transmitted frame report
	input wire logic tx_done,
	input wire logic tx_ok,
	input wire logic [15:0] tx_octets,
	input wire logic [47:0] tx_dest,
	input wire logic tx_urgent,
	// Link status and training
	input wire logic [2:0] link_open_state,
	input wire logic init_open,
	input wire logic train_rsp_valid,
	input wire logic train_rsp_ok,
	input wire logic train_by_node,
	input wire logic [15:0] train_rsp_cfg,
	// Settings toward training and address logic
	output logic [1:0] req_frame_format,
	output logic req_accept_all,
	output logic accept_all_granted,
	output logic [31:0] fa_mask_active
	);

	logic [FC_W-1:0] fcnt [NUM_FC]; // Frame counters
	logic [OC_W-1:0] ocnt [NUM_OC]; // Octet counters
	logic [NUM_FC-1:0] fc_inc; // Frame strobes
	logic [NUM_OC-1:0] oc_inc; // Octet strobes
	logic [OC_W-1:0] rx_amt; // Rx octet increment
	logic [OC_W-1:0] tx_amt; // Tx octet increment
	logic [2:0] ctrl; // Wanted format and accept-all request
	logic [31:0] functional_addr_mask; // Functional address mask
	logic [15:0] granted_train_cfg; // Last granted configuration
	logic [31:0] snap_hi; // Upper half latched on low read
	logic link_open; // Training done
	logic [1:0] fmt_field; // Granted format bits
	logic second_mode; // Operating in second format
	logic tx_grp; // Tx group address
	logic tx_bc; // Tx broadcast address
	logic setup; // APB setup phase
	logic access; // APB completing access
	logic [11:0] a; // Local byte offset
	logic [3:0] fc_idx; // Frame counter index
	logic [2:0] oc_idx; // Octet counter index
	logic rd_err; // Address not mapped
	logic wr_ok; // Write target is writable
	logic oc_lo; // Access to an octet low word
	logic [31:0] rd_val; // Read data mux

	ensc_rx_if rxi();

	// Frame facts into the classifier
	assign rxi.done = rx_done;
	assign rxi.octets = rx_octets;
	assign rxi.dest = rx_dest;
	assign rxi.urgent = rx_urgent;
	assign rxi.null_addr = rx_null_addr;
	assign rxi.fcs_bad = rx_fcs_bad;
	assign rxi.marker = rx_marker;
	assign rxi.medium_err = rx_medium_err;
	assign rxi.undersize = rx_undersize;
	assign rxi.bad_start = rx_bad_start;
	assign rxi.bad_end = rx_bad_end;

	// Open only after successful training
	assign link_open = (link_open_state == LS_OPENED);
	assign fmt_field = granted_train_cfg[CFG_FMT_LSB +: 2];
	assign second_mode = link_open && (fmt_field != 2'h0);
	// Smaller limit unless open in large framing
	assign rxi.use_small = !link_open || (fmt_field == 2'h0);

	ensc_rx_classify u_cls (
		.rx(rxi.cls)
	);

	// Transmit strobes
	assign tx_grp = tx_dest[GROUP_BIT];
	assign tx_bc = (tx_dest == BCAST_ADDR);
	assign fc_inc[NUM_RX_FC-1:0] = rxi.fc_inc;
	assign fc_inc[TX_URG] = tx_done && tx_urgent && tx_ok;
	assign fc_inc[TX_TOT] = tx_done;
	assign fc_inc[TX_BC] = tx_done && tx_grp && tx_bc;
	assign fc_inc[TX_MC] = tx_done && tx_grp && !tx_bc;
	assign oc_inc[NUM_RX_OC-1:0] = rxi.oc_inc;
	assign oc_inc[O_TX_URG] = tx_done && tx_urgent && tx_ok;
	assign oc_inc[O_TX_TOT] = tx_done;
	assign rx_amt = {48'h0, rx_octets};
	assign tx_amt = {48'h0, tx_octets};

	// Counter banks
	for (genvar i = 0; i < NUM_FC; i++) begin : g_fc
		ensc_counter #(.W(FC_W)) u_fc (
			.pclk(pclk),
			.presetn(presetn),
			.en(fc_inc[i]),
			.amt(32'h1),
			.cnt(fcnt[i])
		);
	end
	for (genvar j = 0; j < NUM_OC; j++) begin : g_oc
		ensc_counter #(.W(OC_W)) u_oc (
			.pclk(pclk),
			.presetn(presetn),
			.en(oc_inc[j]),
			.amt((j < NUM_RX_OC) ? rx_amt : tx_amt),
			.cnt(ocnt[j])
		);
	end

	// APB phase decode
	assign setup = psel && !penable;
	assign access = psel && penable && pready;
	assign a = paddr[11:0];
	assign fc_idx = a[5:2];
	assign oc_idx = a[5:3];
	assign oc_lo = (a[11:6] == OC_BASE[11:6]) && !a[2];

	// Read mux and map check; counters are never writable
	always_comb begin
		rd_val = 32'h0;
		rd_err = 1'b0;
		wr_ok = 1'b0;
		if ((paddr[31:12] != 20'h0) || (a[1:0] != 2'h0)) begin
			rd_err = 1'b1;
		end else if (a[11:6] == FC_BASE[11:6]) begin
			// Frame counters, read only
			if (fc_idx <= FC_LAST) begin
				rd_val = fcnt[fc_idx];
			end else begin
				rd_err = 1'b1;
			end
		end else if (a[11:6] == OC_BASE[11:6]) begin
			// Octet counters, low word then latched high word
			if (oc_idx <= OC_LAST) begin
				rd_val = a[2] ? snap_hi : ocnt[oc_idx][31:0];
			end else begin
				rd_err = 1'b1;
			end
		end else begin
			case (a)
				CTRL_OFF: begin
					rd_val = {29'h0, ctrl};
					wr_ok = 1'b1;
				end
				FMASK_OFF: begin
					rd_val = functional_addr_mask;
					wr_ok = 1'b1;
				end
				TCFG_OFF: rd_val = {16'h0, granted_train_cfg};
				CAPS_OFF: rd_val = {30'h0, SUPPORTED};
				STAT_OFF: rd_val = {24'h0, req_accept_all, req_frame_format, second_mode,
					accept_all_granted, link_open_state};
				default: rd_err = 1'b1;
			endcase
		end
	end

	// One wait-free access cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0;
			pslverr <= 1'b0;
		end else begin
			pready <= setup;
			if (setup) begin
				prdata <= pwrite ? 32'h0 : rd_val;
				pslverr <= rd_err || (pwrite && !wr_ok);
			end else begin
				prdata <= 32'h0;
				pslverr <= 1'b0;
			end
		end
	end

	// Writable settings with byte lanes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl <= CTRL_RST;
			functional_addr_mask <= 32'h0;
		end else if (access && pwrite && wr_ok && !rd_err) begin
			if (a == CTRL_OFF && pstrb[0]) begin
				ctrl <= pwdata[2:0];
			end
			if (a == FMASK_OFF) begin
				for (int b = 0; b < 4; b++) begin
					if (pstrb[b]) begin
						functional_addr_mask[8*b +: 8] <= pwdata[8*b +: 8];
					end
				end
			end
		end
	end

	// Latch upper octet word on low-word read for a coherent pair
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			snap_hi <= 32'h0;
		end else if (access && !pwrite && oc_lo && !rd_err) begin
			snap_hi <= ocnt[oc_idx][63:32];
		end
	end

	// Requests only take effect at the next init or open
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			req_frame_format <= CTRL_RST[1:0];
			req_accept_all <= CTRL_RST[CTRL_ACC_BIT];
		end else if (init_open) begin
			req_frame_format <= ctrl[1:0];
			req_accept_all <= ctrl[CTRL_ACC_BIT];
		end
	end

	// Capture configuration from good node-started responses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			granted_train_cfg <= 16'h0;
		end else if (train_rsp_valid && train_rsp_ok && train_by_node) begin
			granted_train_cfg <= train_rsp_cfg;
		end
	end

	// Grant and mask outputs toward address recognition
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			accept_all_granted <= 1'b0;
			fa_mask_active <= 32'h0;
		end else begin
			accept_all_granted <= link_open && (granted_train_cfg[CFG_ACC_LSB +: 2] != 2'h0);
			fa_mask_active <= second_mode ? functional_addr_mask : 32'h0;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Checks on the receive side
	rx_prio_split_a: assert property (rx_done && !rx_urgent |=>
		fcnt[RX_NORM] == $past(fcnt[RX_NORM]) + 32'h1 && fcnt[RX_URG] == $past(fcnt[RX_URG]))
		else $error("priority split wrong");
	rx_urg_split_a: assert property (rx_done && rx_urgent |=>
		fcnt[RX_URG] == $past(fcnt[RX_URG]) + 32'h1 && fcnt[RX_NORM] == $past(fcnt[RX_NORM])
		&& ocnt[O_RX_URG] == $past(ocnt[O_RX_URG]) + $past(rx_amt))
		else $error("urgent split wrong");
	null_only_a: assert property (rx_done && rx_null_addr && rx_octets >= MIN_NULL_OCT |=>
		fcnt[RX_NULL] == $past(fcnt[RX_NULL]) + 32'h1 && fcnt[RX_GOOD] == $past(fcnt[RX_GOOD])
		&& fcnt[RX_LONG] == $past(fcnt[RX_LONG])) else $error("null frame miscounted");
	oversize_large_a: assert property (rx_done && !rx_null_addr && rx_octets > MAX_LARGE |=>
		fcnt[RX_LONG] == $past(fcnt[RX_LONG]) + 32'h1) else $error("oversize missed");
	oversize_closed_a: assert property (rx_done && !rx_null_addr && !link_open && rx_octets > MAX_SMALL |=>
		fcnt[RX_LONG] == $past(fcnt[RX_LONG]) + 32'h1) else $error("closed oversize missed");
	good_octets_a: assert property (fc_inc[RX_GOOD] |=>
		ocnt[O_RX_GOOD] == $past(ocnt[O_RX_GOOD]) + $past(rx_amt)) else $error("good octets wrong");
	good_bcast_a: assert property (fc_inc[RX_GOOD] && rx_dest == BCAST_ADDR |-> fc_inc[RX_BC] && !fc_inc[RX_MC])
		else $error("broadcast miscounted");
	marker_bad_a: assert property (rx_done && !rx_null_addr && rx_medium_err |-> !fc_inc[RX_MARK])
		else $error("marker with medium error");
	damaged_a: assert property (rx_done && !rx_null_addr && rx_undersize && rx_octets <= MAX_SMALL |=>
		fcnt[RX_DMG] == $past(fcnt[RX_DMG]) + 32'h1) else $error("damaged frame missed");
	// Checks on the transmit side
	tx_total_a: assert property (tx_done |=>
		fcnt[TX_TOT] == $past(fcnt[TX_TOT]) + 32'h1
		&& ocnt[O_TX_TOT] == $past(ocnt[O_TX_TOT]) + $past(tx_amt)) else $error("tx total wrong");
	tx_urgent_a: assert property (tx_done && tx_urgent && tx_ok |=>
		fcnt[TX_URG] == $past(fcnt[TX_URG]) + 32'h1
		&& ocnt[O_TX_URG] == $past(ocnt[O_TX_URG]) + $past(tx_amt)) else $error("tx urgent wrong");
	tx_fail_a: assert property (tx_done && !tx_ok |=> $stable(fcnt[TX_URG]))
		else $error("failed frame counted urgent");
	tx_group_a: assert property (tx_done && tx_dest[GROUP_BIT] |=>
		fcnt[TX_BC] + fcnt[TX_MC] == $past(fcnt[TX_BC]) + $past(fcnt[TX_MC]) + 32'h1)
		else $error("tx group miscounted");
	// Checks on settings and the register bus
	req_latch_a: assert property (init_open |=>
		req_accept_all == $past(ctrl[CTRL_ACC_BIT]) ##1 ($stable(req_accept_all) || $past(init_open)))
		else $error("request not latched");
	train_cfg_a: assert property (train_rsp_valid && !train_rsp_ok |=> $stable(granted_train_cfg))
		else $error("bad response captured");
	mask_gate_a: assert property (!second_mode |=> fa_mask_active == 32'h0)
		else $error("mask leaked outside second format");
	grant_closed_a: assert property (!link_open |=> !accept_all_granted)
		else $error("grant while not open");
	ctr_noclear_a: assert property (setup && pwrite && a[11:6] == FC_BASE[11:6] |=> pslverr)
		else $error("counter write accepted");

	// Scenarios
	good_bcast_c: cover property (fc_inc[RX_BC]);
	tx_urgent_c: cover property (fc_inc[TX_URG] && fc_inc[TX_BC]);
	rx_long_c: cover property (fc_inc[RX_LONG] && link_open);
	marker_c: cover property (fc_inc[RX_MARK] ##1 access && !pwrite);
endmodule : ensc_top

// file: sim/ensc_mac_model.sv
module ensc_mac_model (
	// Clock
	input wire logic pclk,
	// Received frame report
	output logic rx_done,
	output logic [15:0] rx_octets,
	output logic [47:0] rx_dest,
	output logic [7:0] rx_flags,
	// Transmitted frame report
	output logic tx_done,
	output logic tx_ok,
	output logic [15:0] tx_octets,
	output logic [47:0] tx_dest,
	output logic tx_urgent
	);
	timeunit 1ns;
	timeprecision 1ns;

	// Quiet lines at time zero
	initial begin
		rx_done = 1'b0;
		rx_octets = 16'h0000;
		rx_dest = 48'h000000000000;
		rx_flags = 8'h00;
		tx_done = 1'b0;
		tx_ok = 1'b0;
		tx_octets = 16'h0000;
		tx_dest = 48'h000000000000;
		tx_urgent = 1'b0;
	end

	// One receive report; fields scrambled once done has dropped
	task automatic rx_frame(input logic [15:0] oct, input logic [47:0] dest, input logic [7:0] fl);
		@(posedge pclk);
		rx_done <= 1'b1;
		rx_octets <= oct;
		rx_dest <= dest;
		rx_flags <= fl;
		@(posedge pclk);
		rx_done <= 1'b0;
		rx_octets <= ~oct;
		rx_dest <= ~dest;
		rx_flags <= ~fl;
	endtask : rx_frame

	// One transmit report; same scrambling afterwards
	task automatic tx_frame(input logic [15:0] oct, input logic [47:0] dest, input logic ok, input logic urg);
		@(posedge pclk);
		tx_done <= 1'b1;
		tx_octets <= oct;
		tx_dest <= dest;
		tx_ok <= ok;
		tx_urgent <= urg;
		@(posedge pclk);
		tx_done <= 1'b0;
		tx_octets <= ~oct;
		tx_dest <= ~dest;
		tx_ok <= ~ok;
		tx_urgent <= ~urg;
	endtask : tx_frame
endmodule : ensc_mac_model

// file: sim/tb.sv
module tb
	import ensc_pkg::*;
	;
	timeunit 1ns;
	timeprecision 1ns;
	// Clock, reset and APB
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [31:0] paddr, pwdata, prdata;
	// Frame reports from the partner
	logic rx_done, tx_done, tx_ok, tx_urgent;
	logic [15:0] rx_octets, tx_octets;
	logic [47:0] rx_dest, tx_dest;
	logic [7:0] rx_flags;
	// Link and training
	logic [2:0] link_open_state;
	logic init_open, train_rsp_valid, train_rsp_ok, train_by_node;
	logic [15:0] train_rsp_cfg;
	// Settings out
	logic [1:0] req_frame_format;
	logic req_accept_all, accept_all_granted;
	logic [31:0] fa_mask_active;
	// Expected counters and settings
	logic [31:0] fc_exp [NUM_FC];
	logic [63:0] oc_exp [NUM_OC];
	logic [15:0] cfg_exp;
	logic [31:0] mask_exp;
	// Frame lengths around both limits
	localparam logic [15:0] LENS [8] = '{16'h0005, 16'h0006, 16'h05EE, 16'h05EF, 16'h11A8, 16'h11A9, 16'h0040, 16'h0100};
	// Notes of expected APB answers
	typedef struct packed {logic rd; logic [31:0] d; logic e;} ensc_note_s;
	ensc_note_s notes [$];
	ensc_note_s note;
	int err_total, check_count, cyc;

	ensc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_done(rx_done),
		.rx_octets(rx_octets), .rx_dest(rx_dest), .rx_urgent(rx_flags[7]), .rx_null_addr(rx_flags[6]),
		.rx_fcs_bad(rx_flags[5]), .rx_marker(rx_flags[4]), .rx_medium_err(rx_flags[3]), .rx_undersize(rx_flags[2]),
		.rx_bad_start(rx_flags[1]), .rx_bad_end(rx_flags[0]), .tx_done(tx_done), .tx_ok(tx_ok),
		.tx_octets(tx_octets), .tx_dest(tx_dest), .tx_urgent(tx_urgent), .link_open_state(link_open_state),
		.init_open(init_open), .train_rsp_valid(train_rsp_valid), .train_rsp_ok(train_rsp_ok),
		.train_by_node(train_by_node), .train_rsp_cfg(train_rsp_cfg), .req_frame_format(req_frame_format),
		.req_accept_all(req_accept_all), .accept_all_granted(accept_all_granted), .fa_mask_active(fa_mask_active));

	ensc_mac_model mac (.pclk(pclk), .rx_done(rx_done), .rx_octets(rx_octets), .rx_dest(rx_dest),
		.rx_flags(rx_flags), .tx_done(tx_done), .tx_ok(tx_ok), .tx_octets(tx_octets), .tx_dest(tx_dest),
		.tx_urgent(tx_urgent));

	// Free-running clock
	always #50 pclk = ~pclk;

	// Verdict and end of run
	task automatic results();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask : results

	// One comparison
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// One APB transfer; the answer is noted for the monitor
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [31:0] ed,
		input logic ee);
		notes.push_back({~wr, ed, ee});
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= {20'h00000, a};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : apb

	// Plain read
	task automatic rd(input logic [11:0] a, input logic [31:0] ed);
		apb(1'b0, a, 32'h0, ed, 1'b0);
	endtask : rd

	// Monitor takes the oldest note at each answer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (notes.size() == 0) begin
				chk("unexpected answer", 64'h0, 64'h1);
			end else begin
				note = notes.pop_front();
				chk("pslverr", 64'(note.e), 64'(pslverr));
				chk("prdata", note.rd ? 64'(note.d) : 64'h0, 64'(prdata));
			end
		end
	end

	// Hang guard
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			results();
		end
	end

	// Training response; only clean node-started ones are kept
	task automatic train(input logic [15:0] cfg, input logic ok, input logic by);
		if (ok && by) cfg_exp = cfg;
		train_rsp_valid <= 1'b1;
		train_rsp_ok <= ok;
		train_by_node <= by;
		train_rsp_cfg <= cfg;
		@(posedge pclk);
		train_rsp_valid <= 1'b0;
		@(posedge pclk);
	endtask : train

	// Received frame with its expected classification
	task automatic rx_one(input logic [15:0] oct, input logic [47:0] dest, input logic [7:0] fl);
		logic open;
		logic err;
		open = (link_open_state == LS_OPENED);
		err = (fl[5] && !fl[4]) || fl[3] || fl[2] || fl[1] || fl[0];
		fc_exp[fl[7] ? RX_URG : RX_NORM] += 1;
		oc_exp[fl[7] ? O_RX_URG : O_RX_NORM] += 64'(oct);
		if (fl[6] && oct >= 16'h0006) begin
			fc_exp[RX_NULL] += 1;
		end else if (oct > 16'h11A8 || (oct > 16'h05EE && (!open || cfg_exp[12:11] == 2'h0))) begin
			fc_exp[RX_LONG] += 1;
		end else if (!fl[6]) begin
			// Error beats marker beats good
			if (err) begin
				fc_exp[RX_DMG] += 1;
			end else if (fl[4]) begin
				fc_exp[RX_MARK] += 1;
			end else begin
				fc_exp[RX_GOOD] += 1;
				oc_exp[O_RX_GOOD] += 64'(oct);
				if (dest[GROUP_BIT]) fc_exp[dest == 48'hFFFFFFFFFFFF ? RX_BC : RX_MC] += 1;
			end
		end
		mac.rx_frame(oct, dest, fl);
	endtask : rx_one

	// Transmitted frame with its expected counts
	task automatic tx_one(input logic [15:0] oct, input logic [47:0] dest, input logic ok, input logic urg);
		fc_exp[TX_TOT] += 1;
		oc_exp[O_TX_TOT] += 64'(oct);
		if (urg && ok) begin
			fc_exp[TX_URG] += 1;
			oc_exp[O_TX_URG] += 64'(oct);
		end
		if (dest[GROUP_BIT]) fc_exp[dest == 48'hFFFFFFFFFFFF ? TX_BC : TX_MC] += 1;
		mac.tx_frame(oct, dest, ok, urg);
	endtask : tx_one

	// Broadcast, other group or single station
	function automatic logic [47:0] rdest();
		logic [47:0] d;
		d = 48'({$urandom(), $urandom()});
		case ($urandom_range(2))
			0: d = 48'hFFFFFFFFFFFF;
			1: d[GROUP_BIT] = 1'b1;
			default: d[GROUP_BIT] = 1'b0;
		endcase
		return d;
	endfunction : rdest

	// Every counter, octet counters low word first
	task automatic rd_all();
		for (int i = 0; i < NUM_FC; i++) rd(FC_BASE + 12'(4 * i), fc_exp[i]);
		for (int j = 0; j < NUM_OC; j++) begin
			rd(OC_BASE + 12'(8 * j), oc_exp[j][31:0]);
			rd(OC_BASE + 12'(8 * j + 4), oc_exp[j][63:32]);
		end
	endtask : rd_all

	// Main sequence
	initial begin
		logic [15:0] cfg;
		logic open;
		logic [1:0] prev;
		logic [7:0] fl;
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		link_open_state = 3'h0;
		init_open = 1'b0;
		train_rsp_valid = 1'b0;
		train_rsp_ok = 1'b0;
		train_by_node = 1'b0;
		train_rsp_cfg = 16'h0000;
		cfg_exp = 16'h0000;
		mask_exp = 32'hA5C30F96;
		foreach (fc_exp[i]) fc_exp[i] = 32'h0;
		foreach (oc_exp[i]) oc_exp[i] = 64'h0;
		void'($urandom(32'h66FC4D17));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		// Reset values and read-only places
		rd(CTRL_OFF, 32'h3);
		rd(CAPS_OFF, 32'h3);
		rd(TCFG_OFF, 32'h0);
		rd(STAT_OFF, 32'h60);
		apb(1'b1, FC_BASE, 32'hFFFFFFFF, 32'h0, 1'b1);
		apb(1'b1, OC_BASE, 32'hFFFFFFFF, 32'h0, 1'b1);
		apb(1'b1, CAPS_OFF, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'hFFC, 32'h0, 32'h0, 1'b1);
		apb(1'b0, 12'h081, 32'h0, 32'h0, 1'b1);
		apb(1'b1, FMASK_OFF, mask_exp, 32'h0, 1'b0);
		rd(FMASK_OFF, mask_exp);
		// Four link states: open or not, format bits zero or not
		for (int ph = 0; ph < 4; ph++) begin
			link_open_state <= ph[0] ? LS_OPENED : 3'($urandom_range(7, 2));
			cfg = 16'($urandom());
			cfg[12:11] = ph[1] ? 2'($urandom_range(3, 1)) : 2'h0;
			train(~cfg, 1'b0, 1'b1);
			train(cfg ^ 16'h00FF, 1'b1, 1'b0);
			train(cfg, 1'b1, 1'b1);
			rd(TCFG_OFF, {16'h0000, cfg_exp});
			repeat (30) begin
				fl = 8'($urandom() & $urandom() & $urandom()) ^ 8'(ph << 7);
				fork
					rx_one(LENS[$urandom_range(7)], rdest(), fl);
					tx_one(16'($urandom_range(4521, 1)), rdest(), 1'($urandom()), 1'($urandom()));
				join
			end
			rd_all();
			open = ph[0];
			rd(STAT_OFF, {24'h0, 3'h3, open && cfg_exp[12:11] != 2'h0, open && cfg_exp[9:8] != 2'h0,
				link_open_state});
			chk("accept_all_granted", 64'(open && cfg_exp[9:8] != 2'h0), 64'(accept_all_granted));
			chk("fa_mask_active", 64'(open && cfg_exp[12:11] != 2'h0 ? mask_exp : 32'h0),
				64'(fa_mask_active));
		end
		// Requests held until the next open, each format code
		prev = 2'h3;
		for (int f = 1; f < 4; f++) begin
			apb(1'b1, CTRL_OFF, {29'h0, f[0], f[1:0]}, 32'h0, 1'b0);
			rd(CTRL_OFF, {29'h0, f[0], f[1:0]});
			chk("req_frame_format", 64'(prev), 64'(req_frame_format));
			init_open <= 1'b1;
			@(posedge pclk);
			init_open <= 1'b0;
			@(posedge pclk);
			chk("req_frame_format", 64'(f[1:0]), 64'(req_frame_format));
			chk("req_accept_all", 64'(f[0]), 64'(req_accept_all));
			prev = f[1:0];
		end
		results();
	end
endmodule : tb
